// ---- core/nvm_link_regs.vh ----
// command and protection constants for the serial nonvolatile memory core
// assumes plain Verilog-2005 includers
`ifndef NVM_LINK_REGS_VH
`define NVM_LINK_REGS_VH
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02
`define ST_PPE_BIT 7
`define ST_BG_HI_BIT 3
`define ST_BG_LO_BIT 2
`define ST_LATCH_BIT 1
`define ST_ACTIVE_BIT 0
`define ST_WRITE_MASK 8'h8c
`define BG_NONE 2'h0
`define BG_QUARTER 2'h1
`define BG_HALF 2'h2
`define BG_ALL 2'h3
`define QUARTER_BASE 14'h3000
`define HALF_BASE 14'h2000
`define ADDR_MASK 14'h3fff
`define ADDR_ONE 14'h0001
`define LAST_BIT 3'h7
`define WRITE_TIME_US 10000
`define CLK_MHZ 50
`endif

// ---- core/nvm_link_core.v ----
// serial nonvolatile memory core: command decoder, array, protection
// assumes all link pins are asynchronous to clk and sampled here
`include "nvm_link_regs.vh"
module nvm_link_core #(
    parameter ADDR_W = 14,
    parameter PAGE_W = 5,
    parameter WRITE_CYCLES = `WRITE_TIME_US * `CLK_MHZ
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // serial link pins
    input wire sel_n,
    input wire sclk,
    input wire sdi,
    input wire pause_n,
    input wire guard_n,
    output reg sdo,
    output wire sdo_oe_n,
    // status seen by the system
    output wire write_busy
);
    localparam DEPTH = 1 << ADDR_W;
    localparam S_IDLE = 6'h01;
    localparam S_OPC = 6'h02;
    localparam S_ADDR = 6'h04;
    localparam S_RDATA = 6'h08;
    localparam S_WDATA = 6'h10;
    localparam S_DEAD = 6'h20;

    reg [1:0] sel_sy_ff;
    reg [1:0] sck_sy_ff;
    reg [1:0] sdi_sy_ff;
    reg [1:0] pause_sy_ff;
    reg [1:0] guard_sy_ff;
    reg [1:0] prime_ff;
    reg sck_d_ff;
    reg sel_d_ff;
    reg armed_ff;
    reg [5:0] state_ff;
    reg [7:0] opc_ff;
    reg [7:0] shin_ff;
    reg [7:0] shout_ff;
    reg [2:0] bit_ff;
    reg [3:0] abits_ff;
    reg [ADDR_W-1:0] addr_ff;
    reg [7:0] mem [0:DEPTH-1];
    reg [7:0] pbuf [0:(1<<PAGE_W)-1];
    reg [(1<<PAGE_W)-1:0] pvalid_ff;
    reg [ADDR_W-1:0] pbase_ff;
    reg [PAGE_W-1:0] pptr_ff;
    reg [7:0] stwr_ff;
    reg byte_done_ff;
    reg latch_ff;
    reg ppe_ff;
    reg drive_ff;
    reg wr_stat_ff;
    reg [1:0] bg_ff;
    reg busy_ff;
    reg [31:0] wcnt_ff;
    integer i;

    wire sel_s = sel_sy_ff[1];
    wire sck_s = sck_sy_ff[1];
    wire din = sdi_sy_ff[1];
    wire paused = ~pause_sy_ff[1];
    wire hw_prot = ~guard_sy_ff[1] & ppe_ff;
    wire sck_rise = sck_s & ~sck_d_ff & ~paused & ~sel_s;
    wire sck_fall = ~sck_s & sck_d_ff & ~paused & ~sel_s;
    wire sel_fall = ~sel_s & sel_d_ff;
    wire sel_rise = sel_s & ~sel_d_ff;
    wire [7:0] status = {ppe_ff, 3'b000, bg_ff, latch_ff, busy_ff};
    wire [7:0] shin_nxt = {shin_ff[6:0], din};

    function guarded;
        input [1:0] bg;
        input [ADDR_W-1:0] a;
        begin
            case (bg)
                `BG_NONE: guarded = 1'b0;
                `BG_QUARTER: guarded = a >= `QUARTER_BASE;
                `BG_HALF: guarded = a >= `HALF_BASE;
                default: guarded = 1'b1;
            endcase
        end
    endfunction

    // low address byte joined to the held high bits, top bits dropped
    function [ADDR_W-1:0] join_addr;
        input [ADDR_W-1:0] prev;
        input [7:0] lo;
        begin
            join_addr = {prev[5:0], lo} & `ADDR_MASK;
        end
    endfunction

    function [ADDR_W-1:0] next_addr;
        input [ADDR_W-1:0] a;
        begin
            next_addr = (a + `ADDR_ONE) & `ADDR_MASK;
        end
    endfunction

    wire [ADDR_W-1:0] addr_full = join_addr(addr_ff, shin_nxt);
    wire wr_done = busy_ff & (wcnt_ff == 32'h0000_0000);
    wire opc_end = sck_rise & (state_ff == S_OPC)
                   & (bit_ff == `LAST_BIT) & ~sel_fall;
    // a write starts only on a deselect right after a whole byte
    wire start_ok = sel_rise & (state_ff == S_WDATA) & byte_done_ff
                    & ~busy_ff & latch_ff;
    wire is_stat_wr = (opc_ff == `OP_STATUS_WRITE);
    wire start_stat = start_ok & is_stat_wr & ~hw_prot;
    wire start_page = start_ok & ~is_stat_wr & (|pvalid_ff)
                      & ~guarded(bg_ff, pbase_ff);

    assign sdo_oe_n = ~(drive_ff & ~sel_s & ~paused);
    assign write_busy = busy_ff;

    // pin synchronisers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_sy_ff <= 2'b11;
            sck_sy_ff <= 2'b00;
            sdi_sy_ff <= 2'b00;
            pause_sy_ff <= 2'b11;
            guard_sy_ff <= 2'b11;
            sck_d_ff <= 1'b0;
            sel_d_ff <= 1'b1;
            prime_ff <= 2'b00;
            armed_ff <= 1'b0;
        end else begin
            sel_sy_ff <= {sel_sy_ff[0], sel_n};
            sck_sy_ff <= {sck_sy_ff[0], sclk};
            sdi_sy_ff <= {sdi_sy_ff[0], sdi};
            pause_sy_ff <= {pause_sy_ff[0], pause_n};
            guard_sy_ff <= {guard_sy_ff[0], guard_n};
            sck_d_ff <= sck_s;
            sel_d_ff <= sel_s;
            // select counts as idle only once the pin has crossed over
            prime_ff <= {prime_ff[0], 1'b1};
            if (prime_ff[1] && sel_s)
                armed_ff <= 1'b1;
        end
    end

    // serial protocol
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= S_IDLE;
            opc_ff <= 8'h00;
            shin_ff <= 8'h00;
            shout_ff <= 8'h00;
            bit_ff <= 3'h0;
            abits_ff <= 4'h0;
            addr_ff <= {ADDR_W{1'b0}};
            pvalid_ff <= {(1<<PAGE_W){1'b0}};
            pbase_ff <= {ADDR_W{1'b0}};
            pptr_ff <= {PAGE_W{1'b0}};
            stwr_ff <= 8'h00;
            byte_done_ff <= 1'b0;
        end else begin
            if (sel_fall) begin
                // no frame is taken before a first idle select
                state_ff <= armed_ff ? S_OPC : S_IDLE;
                bit_ff <= 3'h0;
                byte_done_ff <= 1'b0;
                // page buffer must survive status polls during the write
                if (!busy_ff)
                    pvalid_ff <= {(1<<PAGE_W){1'b0}};
            end else if (sel_rise) begin
                state_ff <= S_IDLE;
            end else if (sck_rise && state_ff != S_IDLE
                    && state_ff != S_DEAD) begin
                shin_ff <= shin_nxt;
                bit_ff <= bit_ff + 3'h1;
                byte_done_ff <= bit_ff == `LAST_BIT;
                if (bit_ff == `LAST_BIT) begin
                    case (state_ff)
                        S_OPC: begin
                            opc_ff <= shin_nxt;
                            abits_ff <= 4'h0;
                            case (shin_nxt)
                                `OP_LATCH_SET: state_ff <= S_DEAD;
                                `OP_LATCH_CLEAR: state_ff <= S_DEAD;
                                `OP_STATUS_READ: begin
                                    state_ff <= S_RDATA;
                                    shout_ff <= status;
                                end
                                `OP_STATUS_WRITE: begin
                                    state_ff <= busy_ff ? S_DEAD : S_WDATA;
                                end
                                `OP_ARRAY_READ: state_ff <= S_ADDR;
                                `OP_ARRAY_WRITE: state_ff <= S_ADDR;
                                default: state_ff <= S_DEAD;
                            endcase
                        end
                        S_ADDR: begin
                            abits_ff <= abits_ff + 4'h1;
                            if (abits_ff[0]) begin
                                if (opc_ff == `OP_ARRAY_READ) begin
                                    state_ff <= S_RDATA;
                                    shout_ff <= mem[addr_full];
                                    addr_ff <= next_addr(addr_full);
                                end else begin
                                    state_ff <= busy_ff ? S_DEAD : S_WDATA;
                                    addr_ff <= addr_full;
                                    pbase_ff <= addr_full
                                              & ~{{(ADDR_W-PAGE_W){1'b0}},
                                                 {PAGE_W{1'b1}}};
                                    pptr_ff <= shin_nxt[PAGE_W-1:0];
                                end
                            end else begin
                                addr_ff <= {6'h00, shin_nxt};
                            end
                        end
                        S_WDATA: begin
                            if (opc_ff == `OP_STATUS_WRITE) begin
                                stwr_ff <= shin_nxt & `ST_WRITE_MASK;
                            end else begin
                                pbuf[pptr_ff] <= shin_nxt;
                                pvalid_ff[pptr_ff] <= 1'b1;
                                pptr_ff <= pptr_ff + 1'b1;
                            end
                        end
                        S_RDATA: begin
                            if (opc_ff == `OP_STATUS_READ) begin
                                shout_ff <= status;
                            end else begin
                                shout_ff <= mem[addr_ff];
                                addr_ff <= next_addr(addr_ff);
                            end
                        end
                        default: state_ff <= S_DEAD;
                    endcase
                end
            end
        end
    end

    // internal write timer
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_ff <= 1'b0;
            wr_stat_ff <= 1'b0;
            wcnt_ff <= 32'h0000_0000;
        end else if (start_stat || start_page) begin
            busy_ff <= 1'b1;
            wr_stat_ff <= start_stat;
            wcnt_ff <= WRITE_CYCLES - 1;
        end else if (wr_done) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            wcnt_ff <= wcnt_ff - 32'h0000_0001;
        end
    end

    // write latch: commands set and clear it, every write drops it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_ff <= 1'b0;
        end else if (wr_done) begin
            latch_ff <= 1'b0;
        end else if (opc_end && !busy_ff) begin
            if (shin_nxt == `OP_LATCH_SET) begin
                latch_ff <= 1'b1;
            end else if (shin_nxt == `OP_LATCH_CLEAR) begin
                latch_ff <= 1'b0;
            end
        end
    end

    // nonvolatile status bits, taken when a status write finishes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ppe_ff <= 1'b0;
            bg_ff <= `BG_NONE;
        end else if (wr_done && wr_stat_ff) begin
            ppe_ff <= stwr_ff[`ST_PPE_BIT];
            bg_ff <= {stwr_ff[`ST_BG_HI_BIT], stwr_ff[`ST_BG_LO_BIT]};
        end
    end

    // array commit: buffered page bytes land when the timer runs out
    always @(posedge clk) begin
        if (wr_done && !wr_stat_ff) begin
            for (i = 0; i < (1 << PAGE_W); i = i + 1) begin
                if (pvalid_ff[i]) begin
                    mem[pbase_ff | i[ADDR_W-1:0]] <= pbuf[i];
                end
            end
        end
    end

    // output stage: bits change on serial clock falls only
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_ff <= 1'b0;
            sdo <= 1'b0;
        end else if (sel_rise) begin
            drive_ff <= 1'b0;
        end else if (sck_fall && !sel_fall && state_ff == S_RDATA) begin
            drive_ff <= 1'b1;
            sdo <= shout_ff[`LAST_BIT - bit_ff];
        end
    end
endmodule

// ---- test/nvm_link_core_props.sv ----
// pin assertions for the serial memory core
// assumes a host that keeps sclk low between frames
module nvm_link_core_props #(parameter WRITE_CYCLES = 200) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // link pins
    input wire sel_n,
    input wire sclk,
    input wire pause_n,
    input wire sdo,
    input wire sdo_oe_n,
    input wire write_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [31:0] busy_ff;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            busy_ff <= 32'h0000_0000;
        else
            busy_ff <= write_busy ? busy_ff + 32'h0000_0001 : 32'h0000_0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_sel; $rose(sel_n) |-> ##[1:4] sdo_oe_n; endproperty
    a_sel: assert property (p_sel)
        else $error("output kept after deselect");
    property p_idle; sel_n [*5] |-> sdo_oe_n; endproperty
    a_idle: assert property (p_idle)
        else $error("output driven while idle");
    property p_pause; !pause_n [*5] |-> sdo_oe_n; endproperty
    a_pause: assert property (p_pause)
        else $error("output driven during pause");
    property p_oe; $fell(sdo_oe_n) |-> !$past(sclk, 2); endproperty
    a_oe: assert property (p_oe)
        else $error("drive started off a clock fall");
    property p_sdo; $changed(sdo) |-> !$past(sclk, 2); endproperty
    a_sdo: assert property (p_sdo)
        else $error("output bit changed while sclk high");
    property p_start;
        $rose(write_busy) |-> sel_n && $past(sel_n, 2);
    endproperty
    a_start: assert property (p_start)
        else $error("write began while selected");
    property p_len; $fell(write_busy) |->
        busy_ff >= WRITE_CYCLES - 2 && busy_ff <= WRITE_CYCLES + 2;
    endproperty
    a_len: assert property (p_len)
        else $error("write cycle length wrong");
    property p_rst; $rose(arst_n) |-> sdo_oe_n && !write_busy; endproperty
    a_rst: assert property (p_rst)
        else $error("bad state after reset");
    c_write: cover property ($rose(write_busy));
    c_pause: cover property (!pause_n && !sel_n);
    c_read: cover property ($fell(sdo_oe_n));
endmodule
bind nvm_link_core nvm_link_core_props #(.WRITE_CYCLES(WRITE_CYCLES)) props (
    .clk(clk), .arst_n(arst_n), .sel_n(sel_n), .sclk(sclk),
    .pause_n(pause_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .write_busy(write_busy));

// ---- test/link_host_model.sv ----
// host master model for the serial memory link
// assumes its tasks are entered just after a falling clk edge
module link_host_model (
    input wire clk,
    output reg sel_n = 1'b1,
    output reg sclk = 1'b0,
    output reg sdi = 1'b0,
    output reg pause_n = 1'b1,
    input wire sdo,
    input wire sdo_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] rx;
    // a falling select opens every frame; sdi scrambled between frames
    task sel(input v);
        sel_n = v;
        sdi = ~sdi;
        repeat (6) @(negedge clk);
    endtask
    // one byte msb first, reply bit taken just before the rise
    task xfer(input [7:0] tx);
        int i;
        for (i = 7; i >= 0; i--) begin
            sdi = tx[i];
            repeat (4) @(negedge clk);
            rx[i] = sdo_oe_n ? 1'bz : sdo;
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
    endtask
    task hold(input int n);
        // let the last clock fall be seen before pausing
        repeat (5) @(negedge clk);
        pause_n = 1'b0;
        repeat (n) @(negedge clk);
        pause_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
endmodule

// ---- test/spi_eeprom_access_protect_test.sv ----
// self-checking bench for the serial memory core
// assumes the host model runs sclk at 160 ns beside a 50 MHz clk
module spi_eeprom_access_protect_test;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
        fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg guard_n = 1'b1;
    wire sel_n, sclk, sdi, pause_n, sdo, sdo_oe_n, write_busy;
    int fails = 0;
    int num_checks = 0;
    reg [7:0] s;
    reg [15:0] d;
    int b, j;
    initial begin
        forever #10 clk = ~clk;
    end
    nvm_link_core #(.WRITE_CYCLES(200)) dut (.clk(clk), .arst_n(arst_n),
        .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .pause_n(pause_n),
        .guard_n(guard_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .write_busy(write_busy));
    link_host_model h (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
        .pause_n(pause_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cmd(input [7:0] op);
        h.sel(1'b0);
        h.xfer(op);
        h.sel(1'b1);
    endtask
    task status_read_command;
        h.sel(1'b0);
        h.xfer(8'h05);
        h.xfer(8'h00);
        s = h.rx;
        h.sel(1'b1);
    endtask
    // two-byte read with a pause between the bytes
    task rd(input [15:0] a);
        h.sel(1'b0);
        h.xfer(8'h03);
        h.xfer(a[15:8]);
        h.xfer(a[7:0]);
        h.xfer(8'h00);
        d[15:8] = h.rx;
        h.hold(10);
        h.xfer(8'h00);
        d[7:0] = h.rx;
        h.sel(1'b1);
    endtask
    task wr(input [7:0] pre, op, input [15:0] a, v, input int n, input e);
        int k;
        cmd(pre);
        h.sel(1'b0);
        h.xfer(op);
        if (op == 8'h02) h.xfer(a[15:8]);
        if (op == 8'h02) h.xfer(a[7:0]);
        if (n > 1) h.xfer(v[15:8]);
        if (n > 0) h.xfer(v[7:0]);
        h.sel(1'b1);
        `CHK("busy", e, write_busy)
        if (write_busy === 1'b1) begin
            status_read_command;
            `CHK("write active", 1'b1, s[0])
            for (k = 0; k < 400 && write_busy !== 1'b0; k++) @(negedge clk);
            status_read_command;
            `CHK("latch after write", 1'b0, s[1])
        end
    endtask
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        status_read_command;
        `CHK("status after reset", 8'h00, s)
        cmd(8'h06);
        status_read_command;
        `CHK("status latch set", 8'h02, s)
        wr(8'h04, 8'h02, 16'h0010, 16'h5aa5, 2, 1'b0);
        wr(8'h06, 8'h02, 16'h0010, 16'h5aa5, 2, 1'b1);
        wr(8'h06, 8'h02, 16'h003f, 16'h1122, 2, 1'b1);
        rd(16'h0020);
        `CHK("page wrap", 8'h22, d[15:8])
        wr(8'h06, 8'h02, 16'h0000, 16'h003c, 1, 1'b1);
        wr(8'h06, 8'h02, 16'h3fff, 16'h00c3, 1, 1'b1);
        rd(16'hffff);
        `CHK("read wrap", 16'hc33c, d)
        wr(8'h06, 8'h02, 16'h0010, 16'h0000, 0, 1'b0);
        wr(8'h06, 8'h06, 16'h0000, 16'h0210, 2, 1'b0);
        rd(16'h0010);
        `CHK("array read", 16'h5aa5, d)
        h.sel(1'b0);
        h.xfer(8'hab);
        h.xfer(8'h00);
        `CHK("unknown opcode", 1'b1, sdo_oe_n)
        h.sel(1'b1);
        for (b = 0; b < 4; b++) begin
            wr(8'h06, 8'h01, 16'h0000, 16'(b << 2), 1, 1'b1);
            for (j = 1; j < 4; j++)
                wr(8'h06, 8'h02, 16'(j << 12), 16'h00aa, 1,
                    !(b == 3 || (b == 2 && j > 1) || (b == 1 && j == 3)));
        end
        wr(8'h06, 8'h01, 16'h0000, 16'h008c, 1, 1'b1);
        status_read_command;
        `CHK("status written", 8'h8c, s)
        guard_n = 1'b0;
        wr(8'h06, 8'h01, 16'h0000, 16'h0000, 1, 1'b0);
        status_read_command;
        `CHK("enable kept", 8'h8c, s & 8'h8c)
        guard_n = 1'b1;
        wr(8'h06, 8'h01, 16'h0000, 16'h0000, 1, 1'b1);
        status_read_command;
        `CHK("status cleared", 8'h00, s)
        stop_test;
    end
    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        stop_test;
    end
endmodule
